//--- hw/i2cdac_ctrl.sv
`timescale 1ns/1ps
`include "i2cdac_regs.svh"
module i2cdac_ctrl #(
	parameter int CODE_W = 16,
	parameter bit MID_SCALE = 1'b0
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic link_clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic addr_sel_pin_0_in,
	output logic addr_sel_pin_0_out,
	output logic addr_sel_pin_0_oe_out,
	input wire logic addr_sel_pin_1_in,
	output logic addr_sel_pin_1_out,
	output logic addr_sel_pin_1_oe_out,
	input wire logic addr_sel_pin_2_in,
	output logic addr_sel_pin_2_out,
	output logic addr_sel_pin_2_oe_out,
	input wire logic async_update_n_in,
	output logic [CODE_W-1:0] dac_code_out,
	output logic [CODE_W-1:0] input_code_out,
	output logic power_down_out,
	output logic word_ready_out
);
	import i2cdac_pkg::*;

	localparam logic [15:0] RST_WORD =
		MID_SCALE ? `I2CDAC_MID_SCALE : `I2CDAC_ZERO_SCALE;
	localparam logic [CODE_W-1:0] RST_CODE = RST_WORD[15 -: CODE_W];

	// Level seen on a pin driven high and then low
	function automatic i2cdac_trit_t trit_of(input logic hi, input logic lo);
		if (hi && !lo) begin
			trit_of = TR_FLOAT;
		end else if (hi) begin
			trit_of = TR_VCC;
		end else begin
			trit_of = TR_GND;
		end
	endfunction : trit_of

	// Slave address from the three probed pins
	function automatic logic [6:0] pin_addr(input logic [2:0] hi,
			input logic [2:0] lo);
		logic [4:0] idx;
		logic [2:0] grp;
		idx = 5'h09 * 5'(trit_of(hi[2], lo[2]))
			+ 5'h03 * 5'(trit_of(hi[1], lo[1]))
			+ 5'(trit_of(hi[0], lo[0]));
		grp = idx[4:2] + `I2CDAC_GROUP_STEP;
		pin_addr = {grp, 2'b00, idx[1:0]};
	endfunction : pin_addr

	// Link-side synchronisers for enable, bus lines and address pins
	logic [5:0] lsync;
	logic lce_s, scl_s, sda_s;
	logic [2:0] pins_s;
	i2cdac_sync #(.W(6)) u_lsync (
		.clk_in(link_clk_in),
		.rst_in(rst_in),
		.d_in({ce_in, scl_in, sda_in, addr_sel_pin_2_in,
			addr_sel_pin_1_in, addr_sel_pin_0_in}),
		.q_out(lsync)
	);
	assign {lce_s, scl_s, sda_s, pins_s} = lsync;

	// Bus receiver state
	i2cdac_bus_st_t st_r, st_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [2:0] byte_r, byte_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [23:0] word_r, word_nxt;
	logic ack_r, ack_nxt;
	logic tgl_r, tgl_nxt;
	logic armed_r, armed_nxt;
	logic scl_d_r, scl_d_nxt;
	logic sda_d_r, sda_d_nxt;
	logic start_ev, stop_ev, scl_rise, scl_fall, addr_hit;

	// Address probe state
	i2cdac_probe_st_t pst_r, pst_nxt;
	logic [2:0] pcnt_r, pcnt_nxt;
	logic lvl_r, lvl_nxt;
	logic poe_r, poe_nxt;
	logic [2:0] hi_r, hi_nxt;
	logic [2:0] lo_r, lo_nxt;
	logic [6:0] own_addr_r, own_addr_nxt;

	// Bus line events on the synchronised levels
	assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s;
	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;
	assign addr_hit = (shift_r[7:1] == own_addr_r)
		|| (shift_r[7:1] == `I2CDAC_GLOBAL_ADDR);

	// Receiver next state
	always_comb begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		byte_nxt = byte_r;
		shift_nxt = shift_r;
		word_nxt = word_r;
		ack_nxt = ack_r;
		tgl_nxt = tgl_r;
		armed_nxt = armed_r;
		scl_d_nxt = scl_d_r;
		sda_d_nxt = sda_d_r;
		if (lce_s) begin
			scl_d_nxt = scl_s;
			sda_d_nxt = sda_s;
			if (start_ev) begin
				st_nxt = ST_RECV;
				bit_nxt = 4'h0;
				byte_nxt = 3'h0;
				ack_nxt = 1'b0;
				armed_nxt = 1'b0;
			end else if (stop_ev) begin
				st_nxt = ST_IDLE;
				ack_nxt = 1'b0;
			end else begin
				case (st_r)
					ST_RECV: begin
						if (scl_rise && bit_r != `I2CDAC_BIT_LAST) begin
							shift_nxt = {shift_r[6:0], sda_s};
							bit_nxt = bit_r + 4'h1;
						end else if (scl_fall && bit_r == `I2CDAC_BIT_LAST) begin
							st_nxt = ST_ACK;
							if (byte_r == 3'h0) begin
								if (addr_hit && !shift_r[0]) begin
									ack_nxt = 1'b1;
								end else begin
									st_nxt = ST_SKIP;
								end
							end else if (byte_r <= `I2CDAC_DATA_BYTES) begin
								ack_nxt = 1'b1;
								word_nxt = {word_r[15:0], shift_r};
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							st_nxt = ST_RECV;
							ack_nxt = 1'b0;
							bit_nxt = 4'h0;
							if (byte_r != `I2CDAC_BYTE_SAT) begin
								byte_nxt = byte_r + 3'h1;
							end
							if (byte_r == `I2CDAC_DATA_BYTES) begin
								tgl_nxt = !tgl_r;
								armed_nxt = 1'b1;
							end
						end
					end
					ST_IDLE, ST_SKIP: begin
					end
					default: begin
						st_nxt = ST_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge link_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= ST_IDLE;
			bit_r <= 4'h0;
			byte_r <= 3'h0;
			shift_r <= 8'h00;
			word_r <= 24'h00_0000;
			ack_r <= 1'b0;
			tgl_r <= 1'b0;
			armed_r <= 1'b0;
			scl_d_r <= 1'b0;
			sda_d_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			byte_r <= byte_nxt;
			shift_r <= shift_nxt;
			word_r <= word_nxt;
			ack_r <= ack_nxt;
			tgl_r <= tgl_nxt;
			armed_r <= armed_nxt;
			scl_d_r <= scl_d_nxt;
			sda_d_r <= sda_d_nxt;
		end
	end

	// Probe next state: drive pins high, then low, then decode
	always_comb begin
		pst_nxt = pst_r;
		pcnt_nxt = pcnt_r;
		lvl_nxt = lvl_r;
		poe_nxt = poe_r;
		hi_nxt = hi_r;
		lo_nxt = lo_r;
		own_addr_nxt = own_addr_r;
		if (lce_s) begin
			case (pst_r)
				PR_IDLE: begin
					if (start_ev) begin
						pst_nxt = PR_HIGH;
						pcnt_nxt = 3'h0;
						lvl_nxt = 1'b1;
						poe_nxt = 1'b1;
					end
				end
				PR_HIGH: begin
					pcnt_nxt = pcnt_r + 3'h1;
					if (pcnt_r == `I2CDAC_PROBE_PHASE - 3'h1) begin
						hi_nxt = pins_s;
						pst_nxt = PR_LOW;
						pcnt_nxt = 3'h0;
						lvl_nxt = 1'b0;
					end
				end
				PR_LOW: begin
					pcnt_nxt = pcnt_r + 3'h1;
					if (pcnt_r == `I2CDAC_PROBE_PHASE - 3'h1) begin
						lo_nxt = pins_s;
						pst_nxt = PR_DONE;
						poe_nxt = 1'b0;
					end
				end
				PR_DONE: begin
					own_addr_nxt = pin_addr(hi_r, lo_r);
					pst_nxt = PR_IDLE;
				end
				default: begin
					pst_nxt = PR_IDLE;
					poe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pst_r <= PR_HIGH;
			pcnt_r <= 3'h0;
			lvl_r <= 1'b1;
			poe_r <= 1'b1;
			hi_r <= 3'h0;
			lo_r <= 3'h0;
			own_addr_r <= 7'h00;
		end else begin
			pst_r <= pst_nxt;
			pcnt_r <= pcnt_nxt;
			lvl_r <= lvl_nxt;
			poe_r <= poe_nxt;
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
			own_addr_r <= own_addr_nxt;
		end
	end

	// Pin drivers; SDA only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe_out = ack_r;
	assign addr_sel_pin_0_out = lvl_r;
	assign addr_sel_pin_1_out = lvl_r;
	assign addr_sel_pin_2_out = lvl_r;
	assign addr_sel_pin_0_oe_out = poe_r;
	assign addr_sel_pin_1_oe_out = poe_r;
	assign addr_sel_pin_2_oe_out = poe_r;

	// Core-side synchronisers; word_r is stable long after the toggle
	logic [2:0] csync;
	logic tgl_s, armed_s, upd_n_s;
	i2cdac_sync #(.W(3)) u_csync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.d_in({tgl_r, armed_r, async_update_n_in}),
		.q_out(csync)
	);
	assign {tgl_s, armed_s, upd_n_s} = csync;

	// Converter registers
	logic tgl_d_r, tgl_d_nxt;
	logic upd_d_r, upd_d_nxt;
	logic pend_r, pend_nxt;
	logic [CODE_W-1:0] in_r, in_nxt;
	logic [CODE_W-1:0] dac_r, dac_nxt;
	logic pd_r, pd_nxt;
	logic word_ev, upd_low, fire;
	logic [3:0] cmd;
	logic [CODE_W-1:0] code;

	assign word_ev = tgl_s ^ tgl_d_r;
	assign upd_low = !upd_n_s;
	assign fire = armed_s && upd_low && (upd_d_r || pend_r);
	assign cmd = word_r[`I2CDAC_CMD_HI:`I2CDAC_CMD_LO];
	assign code = word_r[`I2CDAC_DATA_HI -: CODE_W];

	// Command execution and asynchronous update
	always_comb begin
		tgl_d_nxt = tgl_d_r;
		upd_d_nxt = upd_d_r;
		pend_nxt = pend_r;
		in_nxt = in_r;
		dac_nxt = dac_r;
		pd_nxt = pd_r;
		if (ce_in) begin
			tgl_d_nxt = tgl_s;
			upd_d_nxt = upd_n_s;
			if (fire) begin
				dac_nxt = in_r;
				pd_nxt = 1'b0;
				pend_nxt = 1'b0;
			end
			if (word_ev) begin
				pend_nxt = 1'b1;
				case (cmd)
					`I2CDAC_CMD_WRITE: begin
						in_nxt = code;
					end
					`I2CDAC_CMD_UPDATE: begin
						dac_nxt = in_r;
						pd_nxt = 1'b0;
					end
					`I2CDAC_CMD_WR_UPD: begin
						in_nxt = code;
						dac_nxt = code;
						pd_nxt = 1'b0;
					end
					`I2CDAC_CMD_PWRDN: begin
						if (!upd_low) begin
							pd_nxt = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tgl_d_r <= 1'b0;
			upd_d_r <= 1'b0;
			pend_r <= 1'b0;
			in_r <= RST_CODE;
			dac_r <= RST_CODE;
			pd_r <= 1'b0;
		end else begin
			tgl_d_r <= tgl_d_nxt;
			upd_d_r <= upd_d_nxt;
			pend_r <= pend_nxt;
			in_r <= in_nxt;
			dac_r <= dac_nxt;
			pd_r <= pd_nxt;
		end
	end

	assign dac_code_out = dac_r;
	assign input_code_out = in_r;
	assign power_down_out = pd_r;
	assign word_ready_out = armed_s;

	// Checks on the link side
	AST_START_OPENS: assert property (@(posedge link_clk_in)
		disable iff (rst_in)
		(lce_s && start_ev) |=> (st_r == ST_RECV && bit_r == 4'h0
		&& byte_r == 3'h0 && !armed_r))
		else $error("START did not open a transaction");
	AST_STOP_FREES: assert property (@(posedge link_clk_in)
		disable iff (rst_in)
		(lce_s && stop_ev) |=> (st_r == ST_IDLE && !sda_oe_out))
		else $error("STOP did not free the bus");
	AST_SAMPLE_RISE: assert property (@(posedge link_clk_in)
		disable iff (rst_in)
		(lce_s && st_r == ST_RECV && scl_rise && !start_ev && !stop_ev
		&& bit_r != `I2CDAC_BIT_LAST) |=> (shift_r[0] == $past(sda_s)
		&& bit_r == $past(bit_r) + 4'h1))
		else $error("Bit not sampled on SCL rise");
	AST_SDA_QUIET: assert property (@(posedge link_clk_in)
		disable iff (rst_in)
		sda_oe_out |-> st_r == ST_ACK)
		else $error("SDA driven outside acknowledge");
	AST_ACK_HOLD: assert property (@(posedge link_clk_in)
		disable iff (rst_in)
		(lce_s && ack_r && scl_rise) |=> (ack_r && st_r == ST_ACK))
		else $error("Acknowledge released during SCL high");
	AST_ADDR_DECODE: assert property (@(posedge link_clk_in)
		disable iff (rst_in)
		(lce_s && pst_r == PR_DONE) |=> own_addr_r == pin_addr(hi_r, lo_r))
		else $error("Pin address not decoded");
	AST_READ_NACK: assert property (@(posedge link_clk_in)
		disable iff (rst_in)
		(lce_s && st_r == ST_RECV && scl_fall && bit_r == `I2CDAC_BIT_LAST
		&& byte_r == 3'h0 && shift_r[0] && !start_ev && !stop_ev)
		|=> (st_r == ST_SKIP && !ack_r))
		else $error("Read request acknowledged");
	AST_EXTRA_NACK: assert property (@(posedge link_clk_in)
		disable iff (rst_in)
		(st_r == ST_ACK && byte_r == `I2CDAC_BYTE_SAT) |-> !ack_r)
		else $error("Extra data byte acknowledged");

	// Checks on the converter side
	AST_UPD_GATED: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(!armed_s && !word_ev) |=> $stable(dac_r))
		else $error("Converter changed without a complete write");
	AST_UPD_COPY: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(ce_in && fire && !word_ev) |=> (dac_r == $past(in_r) && !pd_r))
		else $error("Update pin did not copy input register");
	AST_PD_BLOCKED: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(ce_in && word_ev && cmd == `I2CDAC_CMD_PWRDN && upd_low)
		|=> !pd_r)
		else $error("Power-down taken while update pin low");

endmodule : i2cdac_ctrl

//--- hw/i2cdac_sync.sv
`timescale 1ns/1ps
module i2cdac_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// Two-stage chain; the first stage feeds only the second
	always_comb begin
		meta_nxt = d_in;
		q_nxt = meta_r;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_r <= '0;
			q_out <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_out <= q_nxt;
		end
	end

endmodule : i2cdac_sync

//--- inc/i2cdac_pkg.sv
package i2cdac_pkg;

	// Serial receiver states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RECV = 4'b0010,
		ST_ACK = 4'b0100,
		ST_SKIP = 4'b1000
	} i2cdac_bus_st_t;

	// Address-pin probe states
	typedef enum logic [3:0] {
		PR_IDLE = 4'b0001,
		PR_HIGH = 4'b0010,
		PR_LOW = 4'b0100,
		PR_DONE = 4'b1000
	} i2cdac_probe_st_t;

	// Three-state level of one address-select pin
	typedef enum logic [1:0] {
		TR_GND = 2'h0,
		TR_FLOAT = 2'h1,
		TR_VCC = 2'h2
	} i2cdac_trit_t;

endpackage : i2cdac_pkg

//--- inc/i2cdac_regs.svh
`ifndef I2CDAC_REGS_SVH
`define I2CDAC_REGS_SVH

// Hardwired global slave address, answered besides the pin address
`define I2CDAC_GLOBAL_ADDR 7'h73
// Base of the pin-selected address groups (upper three address bits)
`define I2CDAC_GROUP_STEP 3'h1

// Field positions in the 24-bit received word
`define I2CDAC_CMD_HI 23
`define I2CDAC_CMD_LO 20
`define I2CDAC_DATA_HI 15

// Command codes
`define I2CDAC_CMD_WRITE 4'h0
`define I2CDAC_CMD_UPDATE 4'h1
`define I2CDAC_CMD_WR_UPD 4'h3
`define I2CDAC_CMD_PWRDN 4'h4
`define I2CDAC_CMD_NOP 4'hF

// Power-on codes of the converter register
`define I2CDAC_ZERO_SCALE 16'h0000
`define I2CDAC_MID_SCALE 16'h8000

// Byte and bit counting on the serial link
`define I2CDAC_BIT_LAST 4'h8
`define I2CDAC_DATA_BYTES 3'h3
`define I2CDAC_BYTE_SAT 3'h4

// Link-clock cycles per address-pin probe phase
`define I2CDAC_PROBE_PHASE 3'h4

`endif

//--- testbench/i2cdac_master.sv
`timescale 1ns/1ps
// Bus master model: open-drain lows on SDA, SCL driven high and low, steps on core clock edges
module i2cdac_master (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	// Both lines released at power-up
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// Let n clock edges pass
	task automatic tk(input int n);
		repeat (n) @(posedge clk_in);
	endtask : tk

	// Start or repeated start
	task automatic start();
		tk(1);
		sda_low_out <= 1'b0;
		tk(4);
		scl_out <= 1'b1;
		tk(4);
		sda_low_out <= 1'b1;
		tk(4);
		scl_out <= 1'b0;
	endtask : start

	// Stop frees the bus
	task automatic stop();
		tk(1);
		sda_low_out <= 1'b1;
		tk(4);
		scl_out <= 1'b1;
		tk(4);
		sda_low_out <= 1'b0;
		tk(4);
	endtask : stop

	// One clock pulse; wire sampled early and late in the high phase
	task automatic bit_tx(input logic b, output logic [1:0] s);
		tk(1);
		sda_low_out <= !b;
		tk(4);
		scl_out <= 1'b1;
		tk(2);
		s[1] = sda_in;
		tk(2);
		s[0] = sda_in;
		scl_out <= 1'b0;
	endtask : bit_tx

	// Send n bytes MSB first; collect acks, flag any pull during data
	task automatic xfer(input logic [39:0] w, input int n, input bit stp,
		output logic [4:0] acks, output logic clean);
		logic [1:0] s;
		logic [7:0] d;
		acks = 5'h0;
		clean = 1'b1;
		start();
		for (int k = 0; k < n; k++) begin
			d = w[39-8*k -: 8];
			for (int i = 7; i >= 0; i--) begin
				bit_tx(d[i], s);
				if (s !== {2{d[i]}}) clean = 1'b0;
			end
			bit_tx(1'b1, s);
			acks = {acks[3:0], s === 2'b00};
		end
		if (stp) stop();
	endtask : xfer
endmodule : i2cdac_master

//--- testbench/test_i2c_dac_write_control.sv
`timescale 1ns/1ps
module test_i2c_dac_write_control;
	logic clk_in = 1'b0;
	logic link_clk = 1'b0;
	logic rst_in = 1'b1;
	logic upd_n = 1'b1;
	logic ce = 1'b1;
	logic p0 = 1'b0;
	logic p2 = 1'b0;
	logic scl, m_low, sda_w, sda_o, sda_oe;
	logic [2:0] p_o, p_oe;
	logic p1_keep = 1'b0;
	logic p1;
	logic [15:0] dac, inp;
	logic pd, wrdy, cl;
	logic [4:0] a;
	int error_cnt = 0;
	int n_compared = 0;

	// Clocks of both domains
	always #25 clk_in = !clk_in;
	always #7.5 link_clk = !link_clk;

	// Pulled-up data wire; middle address pin floats and follows drive
	assign sda_w = !m_low && !(sda_oe && !sda_o);
	assign p1 = p_oe[1] ? p_o[1] : p1_keep;
	always @(posedge link_clk) p1_keep <= p1;

	i2cdac_ctrl #(.CODE_W(16), .MID_SCALE(1'b0)) u_dut (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
		.link_clk_in(link_clk), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_o), .sda_oe_out(sda_oe),
		.addr_sel_pin_0_in(p0), .addr_sel_pin_0_out(p_o[0]),
		.addr_sel_pin_0_oe_out(p_oe[0]),
		.addr_sel_pin_1_in(p1), .addr_sel_pin_1_out(p_o[1]),
		.addr_sel_pin_1_oe_out(p_oe[1]),
		.addr_sel_pin_2_in(p2), .addr_sel_pin_2_out(p_o[2]),
		.addr_sel_pin_2_oe_out(p_oe[2]),
		.async_update_n_in(upd_n), .dac_code_out(dac),
		.input_code_out(inp), .power_down_out(pd),
		.word_ready_out(wrdy)
	);

	i2cdac_master u_m (
		.clk_in(clk_in), .sda_in(sda_w),
		.scl_out(scl), .sda_low_out(m_low)
	);

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk

	// Full transfer with stop, then ack pattern and clean data phase
	task automatic wr(input logic [39:0] w, input int n,
		input logic [4:0] ea);
		u_m.xfer(w, n, 1'b1, a, cl);
		u_m.tk(8);
		chk(16'(a), 16'(ea));
		chk(16'(cl), 16'h0001);
	endtask : wr

	// Verdict and end of run
	task automatic results();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// Cut a hang short
	initial begin
		repeat (100000) @(posedge clk_in);
		$display("ERROR %0t: timeout", $time);
		error_cnt++;
		results();
	end

	// Main sequence; pin address 0x13, global 0x73
	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		u_m.tk(12);
		chk(dac, 16'h0000);
		chk(inp, 16'h0000);
		chk({11'h0, p_oe, pd, wrdy}, 16'h0000);
		wr({8'h26, 8'h30, 16'h1234, 8'h55}, 5, 5'b11110);
		chk(dac, 16'h1234);
		chk(inp, 16'h1234);
		wr({8'hE6, 8'h0A, 16'hABCD, 8'h00}, 4, 5'b01111);
		chk(inp, 16'hABCD);
		chk(dac, 16'h1234);
		wr({8'h26, 8'h40, 16'h0000, 8'h00}, 4, 5'b01111);
		chk(16'(pd), 16'h0001);
		wr({8'h26, 8'hF0, 16'h0000, 8'h00}, 4, 5'b01111);
		wr({8'h26, 8'h70, 16'h0000, 8'h00}, 4, 5'b01111);
		chk(dac, 16'h1234);
		chk(inp, 16'hABCD);
		chk(16'(pd), 16'h0001);
		wr({8'h26, 8'h1F, 16'h0000, 8'h00}, 4, 5'b01111);
		chk(dac, 16'hABCD);
		chk(16'(pd), 16'h0000);
		wr({8'h27, 8'h00, 16'h0000, 8'h00}, 2, 5'b00000);
		wr({8'h40, 8'h00, 16'h0000, 8'h00}, 3, 5'b00000);
		// Partial word cut by repeated start
		u_m.xfer({8'h26, 8'h00, 16'h7777, 8'h00}, 3, 1'b0, a, cl);
		chk(16'(a), 16'h0007);
		wr({8'h26, 8'hF0, 16'h0000, 8'h00}, 4, 5'b01111);
		chk(inp, 16'hABCD);
		// Update pin after a complete write; enable low holds the core
		wr({8'h26, 8'h00, 16'h5555, 8'h00}, 4, 5'b01111);
		chk(dac, 16'hABCD);
		ce <= 1'b0;
		upd_n <= 1'b0;
		u_m.tk(5);
		chk(dac, 16'hABCD);
		ce <= 1'b1;
		u_m.tk(5);
		chk(dac, 16'h5555);
		upd_n <= 1'b1;
		wr({8'h26, 8'h00, 16'h6666, 8'h00}, 4, 5'b01111);
		// Start then stop without a word clears readiness
		u_m.xfer({8'h26, 8'h00, 16'h0000, 8'h00}, 2, 1'b1, a, cl);
		u_m.tk(8);
		chk(16'(wrdy), 16'h0000);
		upd_n <= 1'b0;
		u_m.tk(5);
		chk(dac, 16'h5555);
		wr({8'h26, 8'h40, 16'h0000, 8'h00}, 4, 5'b01111);
		chk(16'(pd), 16'h0000);
		chk(dac, 16'h6666);
		upd_n <= 1'b1;
		u_m.tk(4);
		// Third address pin tied high moves the pin address to 0x61
		p2 <= 1'b1;
		wr({8'hC2, 8'h00, 16'h2468, 8'h00}, 4, 5'b01111);
		chk(inp, 16'h2468);
		wr({8'h26, 8'h00, 16'h1111, 8'h00}, 4, 5'b00000);
		chk(inp, 16'h2468);
		results();
	end
endmodule : test_i2c_dac_write_control
